// >>> inc/sfpc_cfg.svh
// Offsets, field positions, reset values and codes of the flash sequencer
`ifndef SFPC_CFG_SVH
`define SFPC_CFG_SVH
`define SFPC_IDX_CSR   8'h37
`define SFPC_IDX_KEY   8'h40
`define SFPC_IDX_CMD   8'h41
`define SFPC_IDX_ADRL  8'h42
`define SFPC_IDX_ADRH  8'h43
`define SFPC_IDX_DATA  8'h44
`define SFPC_IDX_RDAT  8'h45
`define SFPC_IDX_STAT  8'h46
`define SFPC_IDX_OPT   8'h47
`define SFPC_CSR_RST   8'h00
`define SFPC_OPT_RST   1'b0
`define SFPC_OPT_BIT   0
`define SFPC_ST_REFUSE 1
`define SFPC_KEY1      8'h56
`define SFPC_KEY2      8'hae
`define SFPC_CMD_PROG  8'h01
`define SFPC_CMD_ERASE 8'h02
`define SFPC_CMD_MASS  8'h03
`define SFPC_CMD_READ  8'h04
`define SFPC_CMD_OPT   8'h05
`define SFPC_CMD_KEY   8'h06
`define SFPC_SECT0_TOP 4'hf
`define SFPC_SECT1_TOP 4'he
`define SFPC_NO_SECT   2'd3
`define SFPC_ERASED    8'hff
`define SFPC_PROT_RD   8'h00
`define SFPC_FRAME_MAX 6'd31
`endif

// >>> inc/sfpc_pkg.sv
// Types of the flash sequencer
package sfpc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_PROG  = 3'b010,
		ST_ERASE = 3'b100
	} sfpc_state_t;
endpackage

// >>> verilog/sfpc_sync.sv
// Two-stage synchroniser for pin levels
`timescale 1ns/10ps
module sfpc_sync (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [3:0] pin_in,
	output logic      [3:0] pin_sync
);
	logic [3:0] meta_reg;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta_reg <= 4'h0;
			pin_sync <= 4'h0;
		end else begin
			meta_reg <= pin_in;
			pin_sync <= meta_reg;
		end
	end
endmodule // sfpc_sync

// >>> verilog/sfpc_link.sv
// Serial link shifter: 32-bit frames in, one reply byte out
`timescale 1ns/10ps
`include "sfpc_cfg.svh"
module sfpc_link (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        sclk_s,
	input  wire logic        sdat_s,
	input  wire logic        reply_load,
	input  wire logic [7:0]  reply_byte,
	output logic             frame_pulse,
	output logic      [31:0] frame_word,
	output logic             sdat_out,
	output logic             sdat_oe
);
	logic       prev_reg;
	logic [5:0] bit_reg;
	logic [3:0] tx_reg;
	logic [7:0] sh_reg;
	wire        rise_w = sclk_s & ~prev_reg;
	wire        fall_w = ~sclk_s & prev_reg;
	wire        tx_w   = (tx_reg != 4'h0);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prev_reg    <= 1'b0;
			bit_reg     <= 6'd0;
			tx_reg      <= 4'h0;
			sh_reg      <= 8'h00;
			frame_pulse <= 1'b0;
			frame_word  <= 32'h0000_0000;
			sdat_out    <= 1'b0;
			sdat_oe     <= 1'b0;
		end else begin
			prev_reg    <= sclk_s;
			frame_pulse <= 1'b0;
			if (reply_load) begin
				tx_reg   <= 4'h8;
				sh_reg   <= reply_byte;
				sdat_out <= reply_byte[7];
				sdat_oe  <= 1'b1;
			end else if (rise_w && tx_w) begin
				tx_reg <= tx_reg - 4'h1;
			end else if (rise_w) begin
				frame_word <= {frame_word[30:0], sdat_s};
				bit_reg    <= (bit_reg == `SFPC_FRAME_MAX) ? 6'd0 : bit_reg + 6'd1;
				frame_pulse <= (bit_reg == `SFPC_FRAME_MAX);
			end else if (fall_w && tx_w) begin
				// Frame's own last fall can trail the load: keep bit 7 up then
				if (tx_reg != 4'h8) begin
					sh_reg   <= {sh_reg[6:0], 1'b0};
					sdat_out <= sh_reg[6];
				end
			end else if (fall_w) begin
				sdat_oe <= 1'b0;
			end
		end
	end
endmodule // sfpc_link

// >>> verilog/sfpc_top.sv
// Flash program/erase sequencer with sector guard, readout protection and link
`timescale 1ns/10ps
`include "sfpc_cfg.svh"
// Operation
// - Erase whole array or one sector at a time.
// - Program one byte per command, only with programming voltage present.
// - Sector erase touches only its own sector's bytes.
// - With a tool attached, every sector and the option bit are writable.
// - Self-programming may change every sector except sector 0.
// - Sectors 0 and 1 are each 4 Kbytes.
// - Sector 0 spans F000h to FFFFh.
// - 8K array holds sectors 0 and 1; other addresses have no sector.
// - Readout protection blocks external reads and program, sector erase and mass erase commands.
// - One option bit switches readout protection.
// - Clearing protection first erases the whole array automatically.
// - Program and erase need a two-key unlock before each command.
// - Link uses serial clock, bidirectional data, reset and voltage/select pins.
// - Tool attached withholds serial pins from the application.
// - Control/status register at 37h resets to 00h, all bits read/write.
module sfpc_top (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        tool_present,
	input  wire logic        prog_voltage_select,
	input  wire logic        incircuit_serial_clock,
	input  wire logic        incircuit_serial_data_in,
	output logic             incircuit_serial_data_out,
	output logic             incircuit_serial_data_oe,
	output logic             app_pins_enable
);
	function automatic logic [1:0] sector_of(input logic [15:0] a);
		if (a[15:12] == `SFPC_SECT0_TOP)
			sector_of = 2'd0;
		else if (a[15:12] == `SFPC_SECT1_TOP)
			sector_of = 2'd1;
		else
			sector_of = `SFPC_NO_SECT;
	endfunction

	logic [7:0]  mem [0:8191];
	logic [3:0]  pins_s;
	logic [7:0]  csr_reg;
	logic [15:0] adr_reg;
	logic [7:0]  dat_reg;
	logic        prot_reg;
	logic        refused_reg;
	logic        key1_reg;
	logic        unlock_reg;
	logic        icc_reg;
	logic        opt_clr_reg;
	logic        mass_reg;
	logic [12:0] ptr_reg;
	logic [12:0] end_reg;
	logic [12:0] op_a_reg;
	logic [7:0]  op_d_reg;
	logic        reply_ld_reg;
	logic [7:0]  reply_reg;
	logic        frame_pulse;
	logic [31:0] frame_word;
	sfpc_pkg::sfpc_state_t state_reg;

	wire tool_s = pins_s[0];
	wire vpp_s  = pins_s[1];
	wire sclk_s = pins_s[2];
	wire sdat_s = pins_s[3];

	sfpc_sync u_sync (
		.clk      (clk),
		.rst_b    (rst_b),
		.pin_in   ({incircuit_serial_data_in, incircuit_serial_clock,
		            prog_voltage_select, tool_present}),
		.pin_sync (pins_s)
	);

	sfpc_link u_link (
		.clk         (clk),
		.rst_b       (rst_b),
		.sclk_s      (sclk_s),
		.sdat_s      (sdat_s),
		.reply_load  (reply_ld_reg),
		.reply_byte  (reply_reg),
		.frame_pulse (frame_pulse),
		.frame_word  (frame_word),
		.sdat_out    (incircuit_serial_data_out),
		.sdat_oe     (incircuit_serial_data_oe)
	);

	// Bus decode: one wait cycle, then the answer
	wire        req_w  = avs_read | avs_write;
	wire        wr_w   = avs_write & ~avs_waitrequest;
	wire [7:0]  idx    = avs_address;
	wire [7:0]  wbyte  = avs_writedata[7:0];
	wire        cmd_wr = wr_w & (idx == `SFPC_IDX_CMD);
	wire        key_wr = wr_w & (idx == `SFPC_IDX_KEY);
	wire        bus_go = cmd_wr | key_wr;
	wire        lnk_go = frame_pulse & icc_reg;
	wire        coll   = bus_go & lnk_go;
	wire        go     = bus_go | lnk_go;
	wire [7:0]  code   = lnk_go ? frame_word[31:24] :
	                     key_wr ? `SFPC_CMD_KEY : avs_writedata[7:0];
	wire [15:0] addr   = lnk_go ? frame_word[23:8] : adr_reg;
	wire [7:0]  data   = lnk_go ? frame_word[7:0] :
	                     key_wr ? avs_writedata[7:0] : dat_reg;
	wire [1:0]  sect   = sector_of(addr);
	wire        idle   = (state_reg == sfpc_pkg::ST_IDLE);

	// Command qualification
	wire is_key  = go & (code == `SFPC_CMD_KEY);
	wire is_prog = go & (code == `SFPC_CMD_PROG);
	wire is_ers  = go & (code == `SFPC_CMD_ERASE);
	wire is_mass = go & (code == `SFPC_CMD_MASS);
	wire is_opt  = go & (code == `SFPC_CMD_OPT);
	wire is_mod  = is_prog | is_ers | is_mass | is_opt;
	wire sect_ok = (sect != `SFPC_NO_SECT) & ((sect != 2'd0) | icc_reg);
	wire code_ok = ((is_prog | is_ers) & sect_ok & ~prot_reg) |
	               (is_mass & icc_reg & ~prot_reg) |
	               (is_opt & icc_reg);
	wire accept  = is_mod & idle & unlock_reg & vpp_s & code_ok;
	wire refuse  = (is_mod & ~accept) | coll;
	wire opt_set = accept & is_opt & data[`SFPC_OPT_BIT];
	wire opt_clr = accept & is_opt & ~data[`SFPC_OPT_BIT] & prot_reg;
	wire ers_go  = accept & (is_ers | is_mass) | opt_clr;
	wire ers_end = (state_reg == sfpc_pkg::ST_ERASE) & (ptr_reg == end_reg);

	// Array write port
	wire        mem_we = (state_reg != sfpc_pkg::ST_IDLE);
	wire [12:0] mem_wa = (state_reg == sfpc_pkg::ST_PROG) ? op_a_reg : ptr_reg;
	wire [7:0]  mem_wd = (state_reg == sfpc_pkg::ST_PROG) ?
	                     (mem[op_a_reg] & op_d_reg) : `SFPC_ERASED;
	wire        in_arr = (sector_of(adr_reg) != `SFPC_NO_SECT);

	// Read mux
	wire [31:0] stat_w = {24'h0, 1'b0, unlock_reg, prot_reg, tool_s,
	                      vpp_s, icc_reg, refused_reg, ~idle};
	wire [31:0] rd_mux =
		(idx == `SFPC_IDX_CSR)  ? {24'h0, csr_reg} :
		(idx == `SFPC_IDX_ADRL) ? {24'h0, adr_reg[7:0]} :
		(idx == `SFPC_IDX_ADRH) ? {24'h0, adr_reg[15:8]} :
		(idx == `SFPC_IDX_DATA) ? {24'h0, dat_reg} :
		(idx == `SFPC_IDX_RDAT) ? {24'h0, in_arr ? mem[adr_reg[12:0]] : 8'h00} :
		(idx == `SFPC_IDX_STAT) ? stat_w :
		(idx == `SFPC_IDX_OPT)  ? {31'h0, prot_reg} : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= ~(req_w & avs_waitrequest);
			if (avs_read & avs_waitrequest)
				avs_readdata <= rd_mux;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			csr_reg <= `SFPC_CSR_RST;
			adr_reg <= 16'h0000;
			dat_reg <= 8'h00;
		end else if (wr_w) begin
			if (idx == `SFPC_IDX_CSR)
				csr_reg <= avs_writedata[7:0];
			if (idx == `SFPC_IDX_ADRL)
				adr_reg[7:0] <= avs_writedata[7:0];
			if (idx == `SFPC_IDX_ADRH)
				adr_reg[15:8] <= avs_writedata[7:0];
			if (idx == `SFPC_IDX_DATA)
				dat_reg <= avs_writedata[7:0];
		end
	end

	// Refused flag: a new refusal wins over a clear
	always_ff @(posedge clk) begin
		if (!rst_b)
			refused_reg <= 1'b0;
		else if (refuse)
			refused_reg <= 1'b1;
		else if (wr_w && idx == `SFPC_IDX_STAT && avs_writedata[`SFPC_ST_REFUSE])
			refused_reg <= 1'b0;
	end

	// Two-key unlock, spent by any modifying command
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			key1_reg   <= 1'b0;
			unlock_reg <= 1'b0;
		end else if (is_key) begin
			key1_reg   <= (data == `SFPC_KEY1);
			unlock_reg <= key1_reg & (data == `SFPC_KEY2);
		end else if (is_mod) begin
			key1_reg   <= 1'b0;
			unlock_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			icc_reg         <= 1'b0;
			app_pins_enable <= 1'b0;
		end else begin
			icc_reg         <= tool_s;
			app_pins_enable <= ~tool_s;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reply_ld_reg <= 1'b0;
			reply_reg    <= 8'h00;
		end else begin
			reply_ld_reg <= lnk_go & (code == `SFPC_CMD_READ);
			if (lnk_go)
				reply_reg <= (prot_reg | sect == `SFPC_NO_SECT) ? `SFPC_PROT_RD :
				             mem[addr[12:0]];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			prot_reg <= `SFPC_OPT_RST;
		else if (opt_set)
			prot_reg <= 1'b1;
		else if (ers_end && opt_clr_reg)
			prot_reg <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg   <= sfpc_pkg::ST_IDLE;
			ptr_reg     <= 13'h0000;
			end_reg     <= 13'h0000;
			op_a_reg    <= 13'h0000;
			op_d_reg    <= 8'h00;
			opt_clr_reg <= 1'b0;
			mass_reg    <= 1'b0;
		end else begin
			unique case (state_reg)
				sfpc_pkg::ST_IDLE: begin
					if (accept && is_prog) begin
						state_reg <= sfpc_pkg::ST_PROG;
						op_a_reg  <= addr[12:0];
						op_d_reg  <= data;
					end else if (ers_go) begin
						state_reg   <= sfpc_pkg::ST_ERASE;
						mass_reg    <= ~is_ers;
						opt_clr_reg <= opt_clr;
						ptr_reg     <= is_ers ? {addr[12], 12'h000} : 13'h0000;
						end_reg     <= is_ers ? {addr[12], 12'hfff} : 13'h1fff;
					end
				end
				sfpc_pkg::ST_PROG:
					state_reg <= sfpc_pkg::ST_IDLE;
				sfpc_pkg::ST_ERASE: begin
					ptr_reg <= ptr_reg + 13'h0001;
					if (ers_end) begin
						state_reg   <= sfpc_pkg::ST_IDLE;
						opt_clr_reg <= 1'b0;
					end
				end
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_accept_prog;
		idle && is_prog && accept;
	endsequence

	sequence s_erase_start;
		idle && ers_go;
	endsequence

	bus_answer_a: assert property (
		(req_w && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle");
	csr_reset_a: assert property ($rose(rst_b) |-> csr_reg == 8'h00)
		else $error("control register not cleared");
	vpp_needed_a: assert property (s_accept_prog |-> vpp_s)
		else $error("programming without voltage");
	prog_one_a: assert property (s_accept_prog |=> state_reg == sfpc_pkg::ST_PROG ##1 idle)
		else $error("program not one cycle");
	prot_block_a: assert property ((is_prog && prot_reg) |=> idle && refused_reg)
		else $error("protected write accepted");
	iap_sector0_a: assert property ((is_mod && !icc_reg && sect == 2'd0) |-> !accept)
		else $error("sector 0 changed without tool");
	guard_key_a: assert property (accept |-> unlock_reg ##1 !unlock_reg)
		else $error("command without unlock");
	sector_span_a: assert property (($rose(state_reg == sfpc_pkg::ST_ERASE) && !mass_reg)
		|-> (end_reg - ptr_reg) == 13'h0fff)
		else $error("sector erase span wrong");
	opt_clear_a: assert property ($fell(prot_reg) |-> $past(mass_reg) && $past(ers_end))
		else $error("protection removed without erase");
	pins_held_a: assert property (tool_s |=> !app_pins_enable)
		else $error("pins left to application");
	prot_read_a: assert property ((reply_ld_reg && prot_reg) |-> reply_reg == 8'h00)
		else $error("protected read leaked data");
	erase_start_a: assert property (s_erase_start |=> state_reg == sfpc_pkg::ST_ERASE)
		else $error("erase did not start");
	erase_done_a: assert property (ers_end |=> idle)
		else $error("erase did not finish");
	erase_inside_a: assert property ((state_reg == sfpc_pkg::ST_ERASE && !mass_reg) |->
		ptr_reg[12] == end_reg[12])
		else $error("sector erase left its sector");
	mass_span_a: assert property ((s_erase_start ##1 mass_reg) |->
		ptr_reg == 13'h0000 && end_reg == 13'h1fff)
		else $error("mass erase span wrong");
	sect0_erase_a: assert property ((accept && is_ers && sect == 2'd0) |=>
		ptr_reg == 13'h1000 && end_reg == 13'h1fff)
		else $error("sector 0 erase range wrong");
	no_sector_a: assert property (((is_prog || is_ers) && sect == `SFPC_NO_SECT) |->
		!accept)
		else $error("command outside the array accepted");
	mass_tool_a: assert property ((is_mass && !icc_reg) |-> !accept)
		else $error("mass erase without tool");
	opt_tool_a: assert property ((is_opt && !icc_reg) |-> !accept)
		else $error("option write without tool");
	prot_write_a: assert property ((prot_reg && (is_prog || is_ers || is_mass)) |->
		!accept)
		else $error("write accepted while protected");
	refuse_flag_a: assert property (refuse |=> refused_reg)
		else $error("refusal not flagged");
	key_spent_a: assert property ((is_mod && !accept) |=> !unlock_reg)
		else $error("unlock kept after refused command");
	pins_free_a: assert property (!tool_s |=> app_pins_enable)
		else $error("pins withheld without tool");
	csr_write_a: assert property ((wr_w && idx == `SFPC_IDX_CSR) |=>
		csr_reg == $past(wbyte))
		else $error("control register write lost");
	out_read_a: assert property ((reply_ld_reg && $past(sect) == `SFPC_NO_SECT) |->
		reply_reg == `SFPC_PROT_RD)
		else $error("read outside the array gave data");
endmodule // sfpc_top

// >>> verification/sfpc_tool_model.sv
// Programming tool model: link clock, data line and reply sampling
`timescale 1ns/10ps
module sfpc_tool_model (
	input  wire logic       dq,
	output logic            sclk,
	output logic            tool_bit,
	output logic      [7:0] reply
);
	initial begin
		sclk = 1'b0;
		tool_bit = 1'b1;
		reply = 8'h00;
	end
	// One frame MSB first; clock idles low outside frames
	task automatic frame(input logic [31:0] w, input logic rd);
		for (int i = 31; i >= 0; i--) begin
			tool_bit = w[i];
			#62.5 sclk = 1'b1;
			#62.5 sclk = 1'b0;
		end
		// Released line keeps no old level
		tool_bit = ~tool_bit;
		if (rd) begin
			#200;
			for (int i = 0; i < 8; i++) begin
				#62.5 sclk = 1'b1;
				reply = {reply[6:0], dq};
				#62.5 sclk = 1'b0;
			end
		end
	endtask
endmodule // sfpc_tool_model

// >>> verification/test_sector_flash_program_control.sv
// Self-checking bench for the flash program/erase sequencer
`timescale 1ns/10ps
`include "sfpc_cfg.svh"
module test_sector_flash_program_control;
	logic        clk;
	logic        rst_b;
	logic        avs_read;
	logic        avs_write;
	logic        tool_present;
	logic        prog_voltage_select;
	logic [7:0]  avs_address;
	logic [7:0]  r;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        sclk;
	logic        tool_bit;
	logic        dq_out;
	logic        dq_oe;
	logic        app_en;
	logic [7:0]  reply;
	wire         dq;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          cyc = 0;
	logic [23:0] rows [7] = '{24'h37a5a5, 24'h375a5a, 24'h37ffff, 24'h370000,
		24'h38ff00, 24'h3f1100, 24'h48ff00};

	assign dq = dq_oe ? dq_out : tool_bit;

	sfpc_top dut_u (
		.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tool_present(tool_present),
		.prog_voltage_select(prog_voltage_select), .incircuit_serial_clock(sclk),
		.incircuit_serial_data_in(dq), .incircuit_serial_data_out(dq_out),
		.incircuit_serial_data_oe(dq_oe), .app_pins_enable(app_en)
	);

	sfpc_tool_model tool_u (
		.dq(dq), .sclk(sclk), .tool_bit(tool_bit), .reply(reply)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic conclude;
		$display("checks %0d, mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			conclude;
		end
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t: got %h, want %h", $time, g, e);
		end
	endtask

	// One bus access; held until the edge that samples waitrequest low
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= w;
		avs_read <= ~w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		r = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	// Address, data, optional unlock, command, wait idle, check refusal
	task automatic cmd(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d,
		input logic k, input logic rf);
		acc(1'b1, `SFPC_IDX_ADRL, a[7:0]);
		acc(1'b1, `SFPC_IDX_ADRH, a[15:8]);
		acc(1'b1, `SFPC_IDX_DATA, d);
		if (k) begin
			acc(1'b1, `SFPC_IDX_KEY, `SFPC_KEY1);
			acc(1'b1, `SFPC_IDX_KEY, `SFPC_KEY2);
		end
		acc(1'b1, `SFPC_IDX_CMD, c);
		do acc(1'b0, `SFPC_IDX_STAT, 8'h00); while (r[0] !== 1'b0);
		chk({7'h00, r[1]}, {7'h00, rf});
		acc(1'b1, `SFPC_IDX_STAT, 8'h02);
	endtask

	task automatic pk(input logic [15:0] a, input logic [7:0] e);
		acc(1'b1, `SFPC_IDX_ADRL, a[7:0]);
		acc(1'b1, `SFPC_IDX_ADRH, a[15:8]);
		acc(1'b0, `SFPC_IDX_RDAT, 8'h00);
		chk(r, e);
	endtask

	initial begin
		rst_b = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h00000000;
		tool_present = 1'b0;
		prog_voltage_select = 1'b1;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		acc(1'b0, `SFPC_IDX_CSR, 8'h00);
		chk(r, `SFPC_CSR_RST);
		acc(1'b0, `SFPC_IDX_STAT, 8'h00);
		chk({7'h00, r[5]}, {7'h00, `SFPC_OPT_RST});
		for (int i = 0; i < 7; i++) begin
			acc(1'b1, rows[i][23:16], rows[i][15:8]);
			acc(1'b0, rows[i][23:16], 8'h00);
			chk(r, rows[i][7:0]);
		end
		chk({7'h00, app_en}, 8'h01);
		$display("registers test done");
		tool_present <= 1'b1;
		repeat (6) @(posedge clk);
		chk({7'h00, app_en}, 8'h00);
		cmd(`SFPC_CMD_MASS, 16'hf000, 8'h00, 1'b1, 1'b0);
		pk(16'hf000, `SFPC_ERASED);
		pk(16'he7ff, `SFPC_ERASED);
		cmd(`SFPC_CMD_PROG, 16'hf000, 8'h3c, 1'b1, 1'b0);
		pk(16'hf000, 8'h3c);
		prog_voltage_select <= 1'b0;
		cmd(`SFPC_CMD_PROG, 16'he010, 8'h55, 1'b1, 1'b1);
		prog_voltage_select <= 1'b1;
		pk(16'he010, `SFPC_ERASED);
		cmd(`SFPC_CMD_PROG, 16'he010, 8'h55, 1'b0, 1'b1);
		pk(16'he010, `SFPC_ERASED);
		$display("tool programming test done");
		tool_present <= 1'b0;
		repeat (6) @(posedge clk);
		cmd(`SFPC_CMD_PROG, 16'hf001, 8'h00, 1'b1, 1'b1);
		pk(16'hf001, `SFPC_ERASED);
		cmd(`SFPC_CMD_ERASE, 16'hf000, 8'h00, 1'b1, 1'b1);
		cmd(`SFPC_CMD_PROG, 16'he020, 8'h12, 1'b1, 1'b0);
		cmd(`SFPC_CMD_PROG, 16'hefff, 8'ha0, 1'b1, 1'b0);
		cmd(`SFPC_CMD_PROG, 16'hd000, 8'h00, 1'b1, 1'b1);
		cmd(`SFPC_CMD_MASS, 16'he000, 8'h00, 1'b1, 1'b1);
		cmd(`SFPC_CMD_OPT, 16'h0000, 8'h01, 1'b1, 1'b1);
		pk(16'hd000, 8'h00);
		pk(16'he020, 8'h12);
		cmd(`SFPC_CMD_ERASE, 16'he123, 8'h00, 1'b1, 1'b0);
		pk(16'he020, `SFPC_ERASED);
		pk(16'hefff, `SFPC_ERASED);
		pk(16'hf000, 8'h3c);
		$display("self-programming test done");
		tool_present <= 1'b1;
		repeat (6) @(posedge clk);
		tool_u.frame(32'h04f00000, 1'b1);
		chk(reply, 8'h3c);
		tool_u.frame(32'h04d00000, 1'b1);
		chk(reply, `SFPC_PROT_RD);
		tool_u.frame(32'h06000056, 1'b0);
		tool_u.frame(32'h060000ae, 1'b0);
		tool_u.frame(32'h01e04077, 1'b0);
		pk(16'he040, 8'h77);
		$display("link test done");
		cmd(`SFPC_CMD_OPT, 16'h0000, 8'h01, 1'b1, 1'b0);
		chk({7'h00, r[5]}, 8'h01);
		cmd(`SFPC_CMD_PROG, 16'he050, 8'h00, 1'b1, 1'b1);
		cmd(`SFPC_CMD_MASS, 16'h0000, 8'h00, 1'b1, 1'b1);
		tool_u.frame(32'h04f00000, 1'b1);
		chk(reply, `SFPC_PROT_RD);
		cmd(`SFPC_CMD_OPT, 16'h0000, 8'h00, 1'b1, 1'b0);
		chk({7'h00, r[5]}, 8'h00);
		pk(16'hf000, `SFPC_ERASED);
		pk(16'he040, `SFPC_ERASED);
		$display("protection test done");
		cmd(`SFPC_CMD_PROG, 16'he001, 8'h5a, 1'b1, 1'b0);
		cmd(`SFPC_CMD_PROG, 16'hf123, 8'h00, 1'b1, 1'b0);
		cmd(`SFPC_CMD_ERASE, 16'hf456, 8'h00, 1'b1, 1'b0);
		pk(16'hf123, `SFPC_ERASED);
		pk(16'he001, 8'h5a);
		$display("sector 0 erase test done");
		conclude;
	end
endmodule // test_sector_flash_program_control
